// ### core/general_timer_unit.sv
// general timer unit: two timer groups behind a wishbone slave
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps

module general_timer_unit
  import gpt_pkg::*;
#(
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // pins
  input  wire logic          core_timer_input,
  input  wire logic          core_direction_input,
  input  wire logic          aux_high_input,
  input  wire logic          group_two_timer_a_input,
  input  wire logic          group_two_timer_a_direction,
  input  wire logic          group_two_core_input,
  input  wire logic          capture_input_pin,
  // outputs
  output logic               core_toggle_output,
  output logic               group_two_toggle_output,
  output logic               group_two_wrap_pulse
);

  logic [31:0]      ctrl_q [NUM_TIMERS];
  logic [TW-1:0]    capture_reload_register_q;
  logic [PRE_W-1:0] pre_q;
  logic [31:0]      dat_q;
  logic             core_lat_q, core_lat_prev_q, g2_lat_q, g2_lat_prev_q;
  logic             ack_q, core_out_q, g2_out_q, g2_wrap_q;
  logic [6:0]       p_lvl, p_rise, p_fall;
  logic [4:0]       tin_l, tin_r, tin_f, tdir_l, tdir_r, tdir_f;
  logic [4:0]       en, down, load, ovf, unf, wr_ctrl, wr_cnt;
  logic [TW-1:0]    load_val [NUM_TIMERS];
  logic [TW-1:0]    cnt [NUM_TIMERS];
  logic             bus_req, bus_wr, wr_capture_reload_register, core_wrap, g2_wrap;
  logic             core_rise_now, core_fall_now, core_lat_rise, core_lat_fall, g2_lat_rise, g2_lat_fall;
  logic             trig_low, trig_high, cap_low, cap_high, cap_g2;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic tick_of(input logic [PRE_W-1:0] pre, input logic [2:0] ps, input int base);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'((32'd1 << (int'(ps) + base)) - 32'd1);
    return &(pre | ~mask);
  endfunction : tick_of

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction : edge_hit

  gpt_pin_sync #(
    .N (7)
  ) u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .pin_in ({capture_input_pin, group_two_core_input, group_two_timer_a_direction,
              group_two_timer_a_input, aux_high_input, core_direction_input, core_timer_input}),
    .level  (p_lvl),
    .rise   (p_rise),
    .fall   (p_fall)
  );

  assign tin_l  = {p_lvl[5], p_lvl[3], p_lvl[2], 1'b0, p_lvl[0]};
  assign tin_r  = {p_rise[5], p_rise[3], p_rise[2], 1'b0, p_rise[0]};
  assign tin_f  = {p_fall[5], p_fall[3], p_fall[2], 1'b0, p_fall[0]};
  assign tdir_l = {1'b0, p_lvl[4], 1'b0, 1'b0, p_lvl[1]};
  assign tdir_r = {1'b0, p_rise[4], 1'b0, 1'b0, p_rise[1]};
  assign tdir_f = {1'b0, p_fall[4], 1'b0, 1'b0, p_fall[1]};

  // free-running prescaler base
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // delayed latches give chain clocks without a loop
  assign core_lat_rise = core_lat_q & ~core_lat_prev_q;
  assign core_lat_fall = ~core_lat_q & core_lat_prev_q;
  assign g2_lat_rise   = g2_lat_q & ~g2_lat_prev_q;
  assign g2_lat_fall   = ~g2_lat_q & g2_lat_prev_q;

  // per-timer count enable and direction
  always_comb begin
    logic [31:0] c;
    logic        tick, ext_edge, quad_a, quad_up;
    c        = '0;
    tick     = 1'b0;
    ext_edge = 1'b0;
    quad_a   = 1'b0;
    quad_up  = 1'b0;
    en       = '0;
    down     = '0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      c = ctrl_q[i];
      tick = (i >= IX_G2A) ? tick_of(pre_q, c[F_PS +: 3], G2_BASE_LOG2)
                           : tick_of(pre_q, c[F_PS +: 3], G1_BASE_LOG2);
      if (c[F_SRC_LAT] && (i == IX_LOW || i == IX_HIGH)) begin
        ext_edge = edge_hit(c[F_EDGE +: 2], core_lat_rise, core_lat_fall);
      end else if (c[F_SRC_LAT] && i == IX_G2A) begin
        ext_edge = edge_hit(c[F_EDGE +: 2], g2_lat_rise, g2_lat_fall);
      end else begin
        ext_edge = edge_hit(c[F_EDGE +: 2], tin_r[i], tin_f[i]);
      end
      quad_a  = tin_r[i] | tin_f[i];
      quad_up = quad_a ? (tin_l[i] ^ tdir_l[i]) : ~(tin_l[i] ^ tdir_l[i]);
      down[i] = c[F_EXT_DIR] ? (c[F_DOWN] ^ tdir_l[i]) : c[F_DOWN];
      unique case (mode_t'(c[F_MODE +: 2]))
        MODE_TIMER: begin
          en[i] = tick;
        end
        MODE_GATED: begin
          en[i] = tick & (tin_l[i] == c[F_GATE_LVL]);
        end
        MODE_COUNTER: begin
          en[i] = ext_edge;
        end
        MODE_INCR: begin
          en[i]   = quad_a | tdir_r[i] | tdir_f[i];
          down[i] = ~quad_up ^ c[F_DOWN];
        end
      endcase
      en[i] = en[i] & c[F_RUN];
      // aux in capture or reload is stopped
      if ((i == IX_LOW || i == IX_HIGH) && func_t'(c[F_FUNC +: 2]) != FUNC_NORMAL) begin
        en[i] = 1'b0;
      end
    end
  end

  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
    gpt_timer16 #(
      .W (TW)
    ) u_tmr (
      .clk      (clk),
      .nrst     (nrst),
      .en       (en[g]),
      .down     (down[g]),
      .load     (load[g]),
      .load_val (load_val[g]),
      .cnt      (cnt[g]),
      .ovf      (ovf[g]),
      .unf      (unf[g])
    );
  end

  // wraps of core and group two core
  assign core_wrap     = ovf[IX_CORE] | unf[IX_CORE];
  assign g2_wrap       = ovf[IX_G2C] | unf[IX_G2C];
  assign core_rise_now = core_wrap & ~core_lat_q;
  assign core_fall_now = core_wrap & core_lat_q;

  assign trig_low  = func_t'(ctrl_q[IX_LOW][F_FUNC +: 2]) == FUNC_RELOAD &&
                     ((ctrl_q[IX_LOW][F_REL_EXT] && edge_hit(ctrl_q[IX_LOW][F_EDGE +: 2], tin_r[IX_LOW],
                                                            tin_f[IX_LOW])) ||
                      (ctrl_q[IX_LOW][F_REL_RISE] && core_rise_now) ||
                      (ctrl_q[IX_LOW][F_REL_FALL] && core_fall_now));
  assign trig_high = func_t'(ctrl_q[IX_HIGH][F_FUNC +: 2]) == FUNC_RELOAD &&
                     ((ctrl_q[IX_HIGH][F_REL_EXT] && edge_hit(ctrl_q[IX_HIGH][F_EDGE +: 2], tin_r[IX_HIGH],
                                                             tin_f[IX_HIGH])) ||
                      (ctrl_q[IX_HIGH][F_REL_RISE] && core_rise_now) ||
                      (ctrl_q[IX_HIGH][F_REL_FALL] && core_fall_now));

  assign cap_low  = func_t'(ctrl_q[IX_LOW][F_FUNC +: 2]) == FUNC_CAPTURE &&
                    edge_hit(ctrl_q[IX_LOW][F_EDGE +: 2], tin_r[IX_LOW], tin_f[IX_LOW]);
  assign cap_high = func_t'(ctrl_q[IX_HIGH][F_FUNC +: 2]) == FUNC_CAPTURE &&
                    edge_hit(ctrl_q[IX_HIGH][F_EDGE +: 2], tin_r[IX_HIGH], tin_f[IX_HIGH]);

  assign cap_g2 = edge_hit(ctrl_q[IX_G2A][F_CAP_EDGE +: 2], p_rise[6], p_fall[6]) ||
                  (ctrl_q[IX_G2A][F_CAP_CIN] && (tin_r[IX_CORE] || tin_f[IX_CORE])) ||
                  (ctrl_q[IX_G2A][F_CAP_CDIR] && (tdir_r[IX_CORE] || tdir_f[IX_CORE]));

  // bus decode
  assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr    = bus_req & wb_we_i;
  assign wr_capture_reload_register = bus_wr && wb_adr_i == OFF_CAPTURE_RELOAD_REGISTER;
  // control and count words sit four bytes apart in timer order
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      wr_ctrl[i] = bus_wr && wb_adr_i == OFF_CORE_CTRL + 8'(4 * i);
      wr_cnt[i]  = bus_wr && wb_adr_i == OFF_CORE_CNT + 8'(4 * i);
    end
  end

  // loads: bus write first, then hardware transfers
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      load[i]     = wr_cnt[i];
      load_val[i] = TW'(merge_bytes(32'(cnt[i]), wb_dat_i, wb_sel_i));
    end
    // core reload, low aux wins a tie
    if (!wr_cnt[IX_CORE] && (trig_low || trig_high)) begin
      load[IX_CORE]     = 1'b1;
      load_val[IX_CORE] = trig_low ? cnt[IX_LOW] : cnt[IX_HIGH];
    end
    if (!wr_cnt[IX_LOW] && cap_low) begin
      load[IX_LOW]     = 1'b1;
      load_val[IX_LOW] = cnt[IX_CORE];
    end
    if (!wr_cnt[IX_HIGH] && cap_high) begin
      load[IX_HIGH]     = 1'b1;
      load_val[IX_HIGH] = cnt[IX_CORE];
    end
    if (!wr_cnt[IX_G2A] && cap_g2 && ctrl_q[IX_G2A][F_CAP_CLR]) begin
      load[IX_G2A]     = 1'b1;
      load_val[IX_G2A] = '0;
    end
    // reload from capture register on wrap
    if (!wr_cnt[IX_G2C] && g2_wrap && ctrl_q[IX_G2C][F_G2_RELD]) begin
      load[IX_G2C]     = 1'b1;
      load_val[IX_G2C] = capture_reload_register_q;
    end
  end

  // control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctrl_q[i] <= CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (wr_ctrl[i]) begin
          ctrl_q[i] <= merge_bytes(ctrl_q[i], wb_dat_i, wb_sel_i) & CTRL_MASK;
        end
      end
    end
  end

  // capture register, capture beats a bus write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capture_reload_register_q <= '0;
    end else if (cap_g2) begin
      capture_reload_register_q <= cnt[IX_G2A];
    end else if (wr_capture_reload_register) begin
      capture_reload_register_q <= TW'(merge_bytes(32'(capture_reload_register_q), wb_dat_i, wb_sel_i));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_lat_q      <= 1'b0;
      core_lat_prev_q <= 1'b0;
      g2_lat_q        <= 1'b0;
      g2_lat_prev_q   <= 1'b0;
    end else begin
      core_lat_q      <= core_lat_q ^ core_wrap;
      core_lat_prev_q <= core_lat_q;
      g2_lat_q        <= g2_lat_q ^ g2_wrap;
      g2_lat_prev_q   <= g2_lat_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_out_q <= 1'b0;
      g2_out_q   <= 1'b0;
      g2_wrap_q  <= 1'b0;
    end else begin
      core_out_q <= ctrl_q[IX_CORE][F_OUT_EN] & core_lat_q;
      g2_out_q   <= ctrl_q[IX_G2C][F_OUT_EN] & g2_lat_q;
      g2_wrap_q  <= g2_wrap;
    end
  end

  // wishbone answer, one wait state, unmapped reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          OFF_CORE_CTRL: dat_q <= ctrl_q[IX_CORE];
          OFF_LOW_CTRL:  dat_q <= ctrl_q[IX_LOW];
          OFF_HIGH_CTRL: dat_q <= ctrl_q[IX_HIGH];
          OFF_G2A_CTRL:  dat_q <= ctrl_q[IX_G2A];
          OFF_G2C_CTRL:  dat_q <= ctrl_q[IX_G2C];
          OFF_CORE_CNT:  dat_q <= 32'(cnt[IX_CORE]);
          OFF_LOW_CNT:   dat_q <= 32'(cnt[IX_LOW]);
          OFF_HIGH_CNT:  dat_q <= 32'(cnt[IX_HIGH]);
          OFF_G2A_CNT:   dat_q <= 32'(cnt[IX_G2A]);
          OFF_G2C_CNT:   dat_q <= 32'(cnt[IX_G2C]);
          OFF_CAPTURE_RELOAD_REGISTER:    dat_q <= 32'(capture_reload_register_q);
          OFF_STATUS:    dat_q <= {30'h0000_0000, g2_lat_q, core_lat_q};
          default:       dat_q <= 32'h0000_0000;
        endcase
      end else begin
        dat_q <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o                = ack_q;
  assign wb_dat_o                = dat_q;
  assign core_toggle_output      = core_out_q;
  assign group_two_toggle_output = g2_out_q;
  assign group_two_wrap_pulse    = g2_wrap_q;

endmodule : general_timer_unit

// ### core/gpt_pkg.sv
// constants and field layout of the general timer unit
package gpt_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CORE_CTRL  = 8'h00;
  localparam logic [7:0] OFF_LOW_CTRL   = 8'h04;
  localparam logic [7:0] OFF_HIGH_CTRL  = 8'h08;
  localparam logic [7:0] OFF_G2A_CTRL   = 8'h0C;
  localparam logic [7:0] OFF_G2C_CTRL   = 8'h10;
  localparam logic [7:0] OFF_CORE_CNT   = 8'h14;
  localparam logic [7:0] OFF_LOW_CNT    = 8'h18;
  localparam logic [7:0] OFF_HIGH_CNT   = 8'h1C;
  localparam logic [7:0] OFF_G2A_CNT    = 8'h20;
  localparam logic [7:0] OFF_G2C_CNT    = 8'h24;
  localparam logic [7:0] OFF_CAPTURE_RELOAD_REGISTER     = 8'h28;
  localparam logic [7:0] OFF_STATUS     = 8'h2C;

  // timer indices
  localparam int NUM_TIMERS = 5;
  localparam int IX_CORE    = 0;
  localparam int IX_LOW     = 1;
  localparam int IX_HIGH    = 2;
  localparam int IX_G2A     = 3;
  localparam int IX_G2C     = 4;

  // control field positions
  localparam int F_MODE     = 0;   // 2 bits
  localparam int F_RUN      = 2;
  localparam int F_DOWN     = 3;
  localparam int F_EXT_DIR  = 4;
  localparam int F_PS       = 5;   // 3 bits
  localparam int F_GATE_LVL = 8;
  localparam int F_OUT_EN   = 9;   // core and group two core
  localparam int F_FUNC     = 10;  // 2 bits, aux timers
  localparam int F_REL_EXT  = 12;
  localparam int F_REL_RISE = 13;
  localparam int F_REL_FALL = 14;
  localparam int F_SRC_LAT  = 15;  // aux and group two timer a
  localparam int F_EDGE     = 16;  // 2 bits: bit0 rising, bit1 falling
  localparam int F_CAP_EDGE = 18;  // 2 bits, group two timer a
  localparam int F_CAP_CIN  = 20;
  localparam int F_CAP_CDIR = 21;
  localparam int F_CAP_CLR  = 22;
  localparam int F_G2_RELD  = 23;  // group two core
  localparam logic [31:0] CTRL_MASK  = 32'h00FF_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // prescaler base divisions
  localparam int G1_BASE_LOG2 = 2;  // four clocks per step
  localparam int G2_BASE_LOG2 = 1;  // two clocks per step
  localparam int PRE_W        = 11;

  typedef enum logic [1:0] {
    MODE_TIMER   = 2'h0,
    MODE_GATED   = 2'h1,
    MODE_COUNTER = 2'h2,
    MODE_INCR    = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    FUNC_NORMAL  = 2'h0,
    FUNC_CAPTURE = 2'h1,
    FUNC_RELOAD  = 2'h2
  } func_t;

endpackage : gpt_pkg

// ### core/gpt_pin_sync.sv
// two-stage pin synchroniser with edge detect
`timescale 1ns/1ps
module gpt_pin_sync #(
  parameter int N = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // raw pins
  input  wire logic [N-1:0] pin_in,
  // synchronised view
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;

endmodule : gpt_pin_sync

// ### core/gpt_timer16.sv
// one up/down timer with load port and wrap events
`timescale 1ns/1ps
module gpt_timer16 #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // control
  input  wire logic         en,
  input  wire logic         down,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // state
  output logic      [W-1:0] cnt,
  output logic              ovf,
  output logic              unf
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (en) begin
      cnt_q <= down ? cnt_q - 1'b1 : cnt_q + 1'b1;
    end
  end

  // wrap events flag even when a load replaces the wrap
  assign ovf = en & ~down & (&cnt_q);
  assign unf = en & down & ~(|cnt_q);
  assign cnt = cnt_q;

endmodule : gpt_timer16

// ### verification/pin_src.sv
// pin-side event source and quadrature sensor model
`timescale 1ns/1ps
module pin_src (
  // clock
  input wire logic       clk,
  // pin levels
  output logic     [6:0] p
);
  logic [1:0] q;
  initial p = 7'h00;
  initial q = 2'h0;
  // level held long enough for the synchroniser
  task automatic lvl(input int i, input logic b);
    p[i] <= b;
    repeat (4) @(posedge clk);
  endtask : lvl
  task automatic pulse(input int i);
    lvl(i, 1'b1);
    lvl(i, 1'b0);
  endtask : pulse
  task automatic step(input logic fwd);
    q = fwd ? {q[0], ~q[1]} : {~q[0], q[1]};
    p[1:0] <= q;
    repeat (4) @(posedge clk);
  endtask : step
endmodule : pin_src

// ### verification/gpt_chk.sv
// assertions on the bus and group two outputs
`timescale 1ns/1ps
module gpt_chk
  import gpt_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // group two outputs
  input wire logic        group_two_toggle_output,
  input wire logic        group_two_wrap_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  a_unmapped_zero: assert property (s_rd ##0 (wb_adr_i >= 8'h30) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_count_width: assert property (
    s_rd ##0 (wb_adr_i >= OFF_CORE_CNT && wb_adr_i <= OFF_CAPTURE_RELOAD_REGISTER) |-> wb_dat_o[31:16] == 16'h0)
    else $error("count upper half not zero");
  a_wrap_gap: assert property (
    group_two_wrap_pulse |=> !group_two_wrap_pulse)
    else $error("wraps closer than two clocks");
  a_g2_out_cause: assert property (
    $changed(group_two_toggle_output) |-> $past(group_two_wrap_pulse) || $past(wb_ack_o))
    else $error("toggle output moved without wrap");
endmodule : gpt_chk
bind general_timer_unit gpt_chk u_chk (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .group_two_toggle_output, .group_two_wrap_pulse);

// ### verification/tb_general_timer_unit.sv
// self-checking bench for the general timer unit
`timescale 1ns/1ps
module tb_general_timer_unit;
  import gpt_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic        ack;
  logic        t3o;
  logic        t6o;
  logic        wrp;
  logic [6:0]  p;
  logic [31:0] v;
  int          error_cnt = 0;
  int          n_checks = 0;
  always #12.5 clk = ~clk;
  general_timer_unit DUT (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .core_timer_input(p[0]), .core_direction_input(p[1]),
    .aux_high_input(p[2]), .group_two_timer_a_input(p[3]), .group_two_timer_a_direction(p[4]),
    .group_two_core_input(p[5]), .capture_input_pin(p[6]), .core_toggle_output(t3o),
    .group_two_toggle_output(t6o), .group_two_wrap_pulse(wrp));
  pin_src u_pins (.clk(clk), .p(p));
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    v = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 40) begin
      error_cnt++;
      stop_test();
    end
  endtask : bus
  task automatic t_regs();
    for (int a = 0; a <= 8'h2C; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      chk("reset value", v, 32'h0);
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", v, 32'h0);
    bus(1'b1, OFF_LOW_CNT, 32'h1234);
    sel <= 4'h1;
    bus(1'b1, OFF_LOW_CNT, 32'hFFFF_FF56);
    sel <= 4'hF;
    bus(1'b0, OFF_LOW_CNT, 32'h0);
    chk("byte lane", v, 32'h1256);
    $display("regs test done");
  endtask : t_regs
  task automatic t_count();
    bus(1'b1, OFF_CORE_CNT, 32'hFFFE);
    bus(1'b1, OFF_CORE_CTRL, 32'h0001_0206);
    repeat (2) u_pins.pulse(0);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("count up", v, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("latch", v, 32'h1);
    chk("out", 32'(t3o), 32'h1);
    bus(1'b1, OFF_CORE_CTRL, 32'h0001_0216);
    u_pins.lvl(1, 1'b1);
    repeat (2) u_pins.pulse(0);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("pin down", v, 32'hFFFE);
    chk("out back", 32'(t3o), 32'h0);
    u_pins.lvl(1, 1'b0);
    bus(1'b1, OFF_CORE_CTRL, 32'h0);
    $display("counter test done");
  endtask : t_count
  task automatic t_quad();
    bus(1'b1, OFF_CORE_CNT, 32'h0);
    bus(1'b1, OFF_CORE_CTRL, 32'h7);
    repeat (3) u_pins.step(1'b1);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("quad fwd", v, 32'h3);
    repeat (4) u_pins.step(1'b0);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("quad back", v, 32'hFFFF);
    u_pins.step(1'b1);
    bus(1'b1, OFF_CORE_CTRL, 32'h0);
    $display("quadrature test done");
  endtask : t_quad
  task automatic t_cap();
    bus(1'b1, OFF_CORE_CNT, 32'h1234);
    bus(1'b1, OFF_HIGH_CTRL, 32'h0001_0404);
    u_pins.pulse(2);
    repeat (8) @(posedge clk);
    bus(1'b0, OFF_HIGH_CNT, 32'h0);
    chk("capture", v, 32'h1234);
    bus(1'b1, OFF_HIGH_CNT, 32'h0ABC);
    bus(1'b1, OFF_HIGH_CTRL, 32'h0001_1800);
    u_pins.pulse(2);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("reload", v, 32'h0ABC);
    bus(1'b1, OFF_HIGH_CTRL, 32'h0);
    $display("capture test done");
  endtask : t_cap
  task automatic t_g2();
    int n;
    n = 0;
    bus(1'b1, OFF_G2C_CNT, 32'hFFFC);
    bus(1'b1, OFF_G2C_CTRL, 32'h204);
    while (wrp !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("wrap", 32'(wrp), 32'h1);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("g2 latch", 32'(v[1]), 32'h1);
    chk("g2 out", 32'(t6o), 32'h1);
    bus(1'b1, OFF_G2C_CTRL, 32'h0);
    bus(1'b1, OFF_G2A_CTRL, 32'h0045_0006);
    repeat (3) u_pins.pulse(3);
    u_pins.pulse(6);
    bus(1'b0, OFF_CAPTURE_RELOAD_REGISTER, 32'h0);
    chk("capture_reload_register", v, 32'h3);
    bus(1'b0, OFF_G2A_CNT, 32'h0);
    chk("cleared", v, 32'h0);
    bus(1'b1, OFF_G2A_CTRL, 32'h0065_0006);
    repeat (2) u_pins.pulse(3);
    u_pins.lvl(1, 1'b1);
    bus(1'b0, OFF_CAPTURE_RELOAD_REGISTER, 32'h0);
    chk("dir capture", v, 32'h2);
    u_pins.lvl(1, 1'b0);
    bus(1'b1, OFF_G2A_CTRL, 32'h0);
    $display("group two test done");
  endtask : t_g2
  // exact windows of 80 and 40 clocks hold whole numbers of prescaler steps
  task automatic t_rate();
    bus(1'b1, OFF_CORE_CNT, 32'h0);
    bus(1'b1, OFF_CORE_CTRL, 32'h24);
    repeat (77) @(posedge clk);
    bus(1'b1, OFF_CORE_CTRL, 32'h0);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("timer rate", v, 32'hA);
    bus(1'b1, OFF_CORE_CNT, 32'h0);
    bus(1'b1, OFF_CORE_CTRL, 32'h105);
    repeat (20) @(posedge clk);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("gate shut", v, 32'h0);
    u_pins.lvl(0, 1'b1);
    repeat (36) @(posedge clk);
    u_pins.lvl(0, 1'b0);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("gate open", v, 32'hA);
    bus(1'b1, OFF_CORE_CTRL, 32'h0);
    $display("rate test done");
  endtask : t_rate
  task automatic t_chain();
    logic l;
    bus(1'b1, OFF_LOW_CNT, 32'h0);
    bus(1'b1, OFF_LOW_CTRL, 32'h0003_8006);
    bus(1'b1, OFF_CORE_CNT, 32'hFFFF);
    bus(1'b1, OFF_CORE_CTRL, 32'h0001_0006);
    u_pins.pulse(0);
    bus(1'b1, OFF_CORE_CNT, 32'hFFFF);
    u_pins.pulse(0);
    bus(1'b0, OFF_LOW_CNT, 32'h0);
    chk("latch clock", v, 32'h2);
    bus(1'b1, OFF_LOW_CNT, 32'h1111);
    bus(1'b1, OFF_HIGH_CNT, 32'h2222);
    bus(1'b1, OFF_LOW_CTRL, 32'h2800);
    bus(1'b1, OFF_HIGH_CTRL, 32'h4800);
    bus(1'b0, OFF_STATUS, 32'h0);
    l = v[0];
    bus(1'b1, OFF_CORE_CNT, 32'hFFFF);
    u_pins.pulse(0);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("reload first", v, l ? 32'h2222 : 32'h1111);
    bus(1'b1, OFF_CORE_CNT, 32'hFFFF);
    u_pins.pulse(0);
    bus(1'b0, OFF_CORE_CNT, 32'h0);
    chk("reload second", v, l ? 32'h1111 : 32'h2222);
    bus(1'b1, OFF_G2C_CNT, 32'h0);
    bus(1'b1, OFF_G2C_CTRL, 32'h0001_0006);
    repeat (2) u_pins.pulse(5);
    bus(1'b0, OFF_G2C_CNT, 32'h0);
    chk("g2 core pin", v, 32'h2);
    bus(1'b1, OFF_G2A_CNT, 32'h10);
    bus(1'b1, OFF_G2A_CTRL, 32'h0001_0016);
    u_pins.lvl(4, 1'b1);
    repeat (2) u_pins.pulse(3);
    u_pins.lvl(4, 1'b0);
    bus(1'b0, OFF_G2A_CNT, 32'h0);
    chk("g2a pin dir", v, 32'hE);
    $display("chain test done");
  endtask : t_chain
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_count();
    t_quad();
    t_cap();
    t_g2();
    t_rate();
    t_chain();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule : tb_general_timer_unit
